/* File: hw/rlsc_regs.svh */
/*
 Register indices, field positions, reset values and timing figures for the
 receive live-status and loop-code register group.
 Assumes nothing of its surroundings; included by bare name.
*/
`ifndef RLSC_REGS_SVH
`define RLSC_REGS_SVH

// register indices; the bus byte address is four times the index
`define RLSC_IDX_UP_LO     8'hac
`define RLSC_IDX_UP_HI     8'had
`define RLSC_IDX_DN_LO     8'hae
`define RLSC_IDX_DN_HI     8'haf
`define RLSC_IDX_ALARM     8'hb0
`define RLSC_IDX_CODE      8'hb2
`define RLSC_IDX_HDLC      8'hb4
`define RLSC_IDX_BYTES     8'hb5
`define RLSC_IDX_LEN       8'hb8
`define RLSC_IDX_MODE      8'hb9
`define RLSC_IDX_FIFOCTL   8'hba
`define RLSC_REG_RESET     8'h00

// alarm live status fields
`define RLSC_ALM_RAI       3
`define RLSC_ALM_AIS       2
`define RLSC_ALM_LOS       1
`define RLSC_ALM_LOF       0
// code / link live status fields
`define RLSC_CODE_RX_CLOCK_LOST     3
`define RLSC_CODE_SPARE    2
`define RLSC_CODE_DN       1
`define RLSC_CODE_UP       0
`define RLSC_CODE_V5       1
`define RLSC_CODE_DMA      0
// hdlc live status fields
`define RLSC_PS_LSB        4
`define RLSC_PS_W          3
`define RLSC_HDLC_HWM      1
`define RLSC_HDLC_NE       0
// bytes available fields
`define RLSC_MS_BIT        7
`define RLSC_CNT_W         7
// control fields
`define RLSC_LEN_UP_LSB    0
`define RLSC_LEN_DN_LSB    4
`define RLSC_LEN_W         4
`define RLSC_MODE_E1       0
`define RLSC_WM_W          6

// detector figures
`define RLSC_LOS_ZEROS     8'hc0
`define RLSC_AIS_ONES      8'hc0
`define RLSC_CHAN_TIME_NS  5180
`define RLSC_CLK_PERIOD_NS 10
`define RLSC_INTEG_BITS    4096

`define RLSC_RESP_OKAY     2'h0
`define RLSC_RESP_SLVERR   2'h2

`endif

/* File: hw/rlsc_pkg.sv */
/*
 Types shared by the receive live-status register group.
 Assumes the constants header supplies all numeric field positions.
*/
package rlsc_pkg;

   typedef enum logic [1:0] {
      RLSC_WR_IDLE = 2'b01,
      RLSC_WR_RESP = 2'b10
   } rlsc_wr_state_e;

   typedef enum logic [2:0] {
      RLSC_PKT_BUSY    = 3'h0,
      RLSC_PKT_GOOD    = 3'h1,
      RLSC_PKT_CRC_ERR = 3'h2,
      RLSC_PKT_ABORT   = 3'h3,
      RLSC_PKT_OVERRUN = 3'h4
   } rlsc_pkt_e;

   typedef logic [7:0] rlsc_byte_t;

endpackage : rlsc_pkg

/* File: hw/rlsc_top.sv */
/*
 Receive live-status and loop-code register group of one framer channel,
 with an AXI4-Lite register slave, loop-up/loop-down code detectors and the
 loss-of-signal, all-ones and receive-clock watchdogs.
 Assumes decoded line bits arrive with a one-cycle valid strobe, and that
 framer sync, remote alarm, spare code, V5 link, TS16 bit and HDLC FIFO
 figures come from neighbouring logic synchronous to core_clk_in.
*/
// Functional notes
// - first pattern register MSB is first bit
// - first register bits beyond length ignored
// - second registers ignored for lengths 1-8
// - first down-code write restarts integration
// - live status bits, never latched
// - alarm bit 3 follows remote alarm
// - alarm bit 2 on unframed all ones
// - alarm bit 1 after 192 zeros
// - alarm bit 0 while framer out of sync
// - code bit 3 on receive clock stall
// - T1 code bit 2 spare code received
// - T1 code bit 1 loop-down received
// - T1 code bit 0 loop-up received
// - E1 code bit 1 V5 link detected
// - E1 bit 0 on two multiframe alarms
// - packet state sampled at FIFO read
// - packet state uses five defined codes
// - hdlc bit 1 above FIFO watermark
// - hdlc bit 0 when FIFO not empty
// - message bit, one when empty
// - lower seven bits: message byte count
`timescale 1ns/1ps
`include "rlsc_regs.svh"

module rlsc_top
   import rlsc_pkg::*;
#(
   parameter int unsigned INTEG_BITS = `RLSC_INTEG_BITS
) (
   input  wire logic        core_clk_in,          // 100 MHz clock
   input  wire logic        rst_n_in,             // sync reset, active low
   input  wire logic        ce_in,                // clock enable
   input  wire logic [9:0]  s_axi_awaddr_in,      // write address
   input  wire logic        s_axi_awvalid_in,     // write address valid
   output logic             s_axi_awready_out,    // write address ready
   input  wire logic [31:0] s_axi_wdata_in,       // write data
   input  wire logic [3:0]  s_axi_wstrb_in,       // write strobes
   input  wire logic        s_axi_wvalid_in,      // write data valid
   output logic             s_axi_wready_out,     // write data ready
   output logic [1:0]       s_axi_bresp_out,      // write response
   output logic             s_axi_bvalid_out,     // write response valid
   input  wire logic        s_axi_bready_in,      // write response ready
   input  wire logic [9:0]  s_axi_araddr_in,      // read address
   input  wire logic        s_axi_arvalid_in,     // read address valid
   output logic             s_axi_arready_out,    // read address ready
   output logic [31:0]      s_axi_rdata_out,      // read data
   output logic [1:0]       s_axi_rresp_out,      // read response
   output logic             s_axi_rvalid_out,     // read data valid
   input  wire logic        s_axi_rready_in,      // read data ready
   input  wire logic        line_bit_in,          // decoded line bit
   input  wire logic        line_bit_valid_in,    // line bit strobe
   input  wire logic        rx_clk_level_in,      // sampled receive clock
   input  wire logic        rx_in_sync_in,        // framer synchronized
   input  wire logic        rx_remote_alarm_in,   // remote alarm seen
   input  wire logic        spare_code_in,        // spare code seen
   input  wire logic        v5_link_in,           // V5 link id seen
   input  wire logic        mf_ts16_bit6_in,      // TS16 frame 0 bit 6
   input  wire logic        mf_ts16_valid_in,     // one per multiframe
   input  wire logic [6:0]  fifo_level_in,        // rx FIFO bytes held
   input  wire logic        fifo_read_in,         // rx FIFO read strobe
   input  wire logic [2:0]  packet_state_in,      // hdlc packet state
   input  wire logic [6:0]  packet_byte_count_in, // message bytes ready
   input  wire logic        msg_end_in            // counted bytes end msg
);

   localparam int RX_CLOCK_LOST_CYC = (`RLSC_CHAN_TIME_NS + `RLSC_CLK_PERIOD_NS - 1)
                             / `RLSC_CLK_PERIOD_NS;
   localparam int LW       = $clog2(RX_CLOCK_LOST_CYC + 1);
   localparam int IW       = $clog2(INTEG_BITS + 1);

   rlsc_byte_t         up_lo_ff, up_hi_ff, dn_lo_ff, dn_hi_ff;
   rlsc_byte_t         len_ff, mode_ff, fifoctl_ff;
   rlsc_byte_t         alarm_ff, code_ff, hdlc_ff, bytes_ff;
   rlsc_byte_t         nxt_alarm, nxt_code, nxt_hdlc, nxt_bytes;
   rlsc_wr_state_e     wr_state_ff;
   logic               aw_have_ff, w_have_ff, w_strb_ff;
   logic [7:0]         aw_idx_ff, w_data_ff;
   logic [1:0]         bresp_ff, rresp_ff;
   logic               rvalid_ff;
   rlsc_byte_t         rdata_ff, rd_byte;
   logic               rd_hit, wr_hit, wr_fire, wr_en;
   logic [1:0]         restart;
   logic [15:0]        hist_ff, hist_nxt;
   logic [1:0]         locked_ff, det_ff;
   logic [IW-1:0]      integ_ff [2];
   logic [7:0]         zero_run_ff, one_run_ff;
   logic               clk_prev_ff;
   logic [LW-1:0]      idle_ff;
   logic [1:0]         mf_hist_ff;
   rlsc_pkt_e          pkt_ff;
   logic               e1_mode;

   assign e1_mode  = mode_ff[`RLSC_MODE_E1];
   assign hist_nxt = {hist_ff[14:0], line_bit_in};

   // bus handshakes stall while the clock enable is low
   assign s_axi_awready_out = ce_in && !aw_have_ff && wr_state_ff == RLSC_WR_IDLE;
   assign s_axi_wready_out  = ce_in && !w_have_ff && wr_state_ff == RLSC_WR_IDLE;
   assign s_axi_bvalid_out  = wr_state_ff == RLSC_WR_RESP;
   assign s_axi_bresp_out   = bresp_ff;
   assign s_axi_arready_out = ce_in && !rvalid_ff;
   assign s_axi_rvalid_out  = rvalid_ff;
   assign s_axi_rresp_out   = rresp_ff;
   assign s_axi_rdata_out   = {24'h000000, rdata_ff};

   assign wr_fire = aw_have_ff && w_have_ff && wr_state_ff == RLSC_WR_IDLE;
   assign wr_en   = wr_fire && wr_hit && w_strb_ff;
   assign restart[0] = wr_en && aw_idx_ff == `RLSC_IDX_UP_LO;
   assign restart[1] = wr_en && aw_idx_ff == `RLSC_IDX_DN_LO;

   always_comb begin
      case (aw_idx_ff)
         `RLSC_IDX_UP_LO, `RLSC_IDX_UP_HI, `RLSC_IDX_DN_LO, `RLSC_IDX_DN_HI,
         `RLSC_IDX_LEN, `RLSC_IDX_MODE, `RLSC_IDX_FIFOCTL: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // address and data may arrive in either order
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         aw_have_ff  <= 1'b0;
         w_have_ff   <= 1'b0;
         aw_idx_ff   <= `RLSC_REG_RESET;
         w_data_ff   <= `RLSC_REG_RESET;
         w_strb_ff   <= 1'b0;
         wr_state_ff <= RLSC_WR_IDLE;
         bresp_ff    <= `RLSC_RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_ff <= 1'b1;
            aw_idx_ff  <= s_axi_awaddr_in[9:2];
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_ff <= 1'b1;
            w_data_ff <= s_axi_wdata_in[7:0];
            w_strb_ff <= s_axi_wstrb_in[0];
         end
         case (wr_state_ff)
            RLSC_WR_IDLE: begin
               if (wr_fire) begin
                  aw_have_ff  <= 1'b0;
                  w_have_ff   <= 1'b0;
                  bresp_ff    <= wr_hit ? `RLSC_RESP_OKAY : `RLSC_RESP_SLVERR;
                  wr_state_ff <= RLSC_WR_RESP;
               end
            end
            RLSC_WR_RESP: begin
               if (s_axi_bready_in) begin
                  wr_state_ff <= RLSC_WR_IDLE;
               end
            end
            default: wr_state_ff <= RLSC_WR_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         up_lo_ff   <= `RLSC_REG_RESET;
         up_hi_ff   <= `RLSC_REG_RESET;
         dn_lo_ff   <= `RLSC_REG_RESET;
         dn_hi_ff   <= `RLSC_REG_RESET;
         len_ff     <= `RLSC_REG_RESET;
         mode_ff    <= `RLSC_REG_RESET;
         fifoctl_ff <= `RLSC_REG_RESET;
      end else if (ce_in && wr_en) begin
         case (aw_idx_ff)
            `RLSC_IDX_UP_LO:   up_lo_ff   <= w_data_ff;
            `RLSC_IDX_UP_HI:   up_hi_ff   <= w_data_ff;
            `RLSC_IDX_DN_LO:   dn_lo_ff   <= w_data_ff;
            `RLSC_IDX_DN_HI:   dn_hi_ff   <= w_data_ff;
            `RLSC_IDX_LEN:     len_ff     <= w_data_ff;
            `RLSC_IDX_MODE:    mode_ff    <= w_data_ff;
            `RLSC_IDX_FIFOCTL: fifoctl_ff <= w_data_ff;
            default:           mode_ff    <= mode_ff;
         endcase
      end
   end

   always_comb begin
      rd_byte = `RLSC_REG_RESET;
      rd_hit  = 1'b1;
      case (s_axi_araddr_in[9:2])
         `RLSC_IDX_UP_LO:   rd_byte = up_lo_ff;
         `RLSC_IDX_UP_HI:   rd_byte = up_hi_ff;
         `RLSC_IDX_DN_LO:   rd_byte = dn_lo_ff;
         `RLSC_IDX_DN_HI:   rd_byte = dn_hi_ff;
         `RLSC_IDX_ALARM:   rd_byte = alarm_ff;
         `RLSC_IDX_CODE:    rd_byte = code_ff;
         `RLSC_IDX_HDLC:    rd_byte = hdlc_ff;
         `RLSC_IDX_BYTES:   rd_byte = bytes_ff;
         `RLSC_IDX_LEN:     rd_byte = len_ff;
         `RLSC_IDX_MODE:    rd_byte = mode_ff;
         `RLSC_IDX_FIFOCTL: rd_byte = fifoctl_ff;
         default:           rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= `RLSC_REG_RESET;
         rresp_ff  <= `RLSC_RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_byte;
            rresp_ff  <= rd_hit ? `RLSC_RESP_OKAY : `RLSC_RESP_SLVERR;
         end else if (s_axi_rready_in) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // one shared bit history feeds both code detectors
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         hist_ff <= 16'h0000;
      end else if (ce_in && line_bit_valid_in) begin
         hist_ff <= hist_nxt;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_det
      logic [15:0] pat;
      logic [3:0]  len_m1;
      logic [4:0]  n;
      logic [15:0] mask;
      logic        match, period_ok;
      // first register MSB leads the pattern
      assign pat    = (g == 0) ? {up_lo_ff, up_hi_ff} : {dn_lo_ff, dn_hi_ff};
      assign len_m1 = (g == 0) ? len_ff[`RLSC_LEN_UP_LSB +: `RLSC_LEN_W]
                               : len_ff[`RLSC_LEN_DN_LSB +: `RLSC_LEN_W];
      assign n      = {1'b0, len_m1} + 5'h01;
      assign mask   = ~(16'hffff >> n);
      assign match  = ((hist_nxt << (5'h10 - n)) & mask) == (pat & mask);
      assign period_ok = hist_nxt[0] == hist_ff[len_m1];

      always_ff @(posedge core_clk_in) begin
         if (!rst_n_in) begin
            locked_ff[g] <= 1'b0;
            integ_ff[g]  <= '0;
            det_ff[g]    <= 1'b0;
         end else if (ce_in) begin
            if (restart[g] || e1_mode) begin
               locked_ff[g] <= 1'b0;
               integ_ff[g]  <= '0;
               det_ff[g]    <= 1'b0;
            end else if (line_bit_valid_in) begin
               if (locked_ff[g] && period_ok) begin
                  if (integ_ff[g] != IW'(INTEG_BITS)) begin
                     integ_ff[g] <= integ_ff[g] + 1'b1;
                  end
                  det_ff[g] <= det_ff[g] || integ_ff[g] >= IW'(INTEG_BITS - 1);
               end else begin
                  locked_ff[g] <= match;
                  integ_ff[g]  <= '0;
                  det_ff[g]    <= 1'b0;
               end
            end
         end
      end
   end

   // zero run after the line decoder, one run for all-ones
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         zero_run_ff <= 8'h00;
         one_run_ff  <= 8'h00;
      end else if (ce_in && line_bit_valid_in) begin
         if (line_bit_in) begin
            zero_run_ff <= 8'h00;
            if (one_run_ff != `RLSC_AIS_ONES) one_run_ff <= one_run_ff + 8'h01;
         end else begin
            one_run_ff <= 8'h00;
            if (zero_run_ff != `RLSC_LOS_ZEROS) zero_run_ff <= zero_run_ff + 8'h01;
         end
      end
   end

   // receive clock watchdog; the input is taken as already synchronous
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         clk_prev_ff <= 1'b0;
         idle_ff     <= '0;
      end else if (ce_in) begin
         clk_prev_ff <= rx_clk_level_in;
         if (rx_clk_level_in != clk_prev_ff) begin
            idle_ff <= '0;
         end else if (idle_ff != LW'(RX_CLOCK_LOST_CYC)) begin
            idle_ff <= idle_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         mf_hist_ff <= 2'h0;
      end else if (ce_in && mf_ts16_valid_in) begin
         mf_hist_ff <= {mf_hist_ff[0], mf_ts16_bit6_in};
      end
   end

   // sample at FIFO read, reject undefined codes
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         pkt_ff <= RLSC_PKT_BUSY;
      end else if (ce_in && fifo_read_in && packet_state_in <= RLSC_PKT_OVERRUN) begin
         pkt_ff <= rlsc_pkt_e'(packet_state_in);
      end
   end

   always_comb begin
      nxt_alarm = `RLSC_REG_RESET;
      nxt_code  = `RLSC_REG_RESET;
      nxt_hdlc  = `RLSC_REG_RESET;
      nxt_bytes = `RLSC_REG_RESET;
      nxt_alarm[`RLSC_ALM_RAI] = rx_remote_alarm_in;
      nxt_alarm[`RLSC_ALM_AIS] = one_run_ff == `RLSC_AIS_ONES && !rx_in_sync_in;
      nxt_alarm[`RLSC_ALM_LOS] = zero_run_ff == `RLSC_LOS_ZEROS;
      nxt_alarm[`RLSC_ALM_LOF] = !rx_in_sync_in;
      nxt_code[`RLSC_CODE_RX_CLOCK_LOST] = idle_ff == LW'(RX_CLOCK_LOST_CYC);
      if (e1_mode) begin
         nxt_code[`RLSC_CODE_V5]  = v5_link_in;
         nxt_code[`RLSC_CODE_DMA] = &mf_hist_ff;
      end else begin
         nxt_code[`RLSC_CODE_SPARE] = spare_code_in;
         nxt_code[`RLSC_CODE_DN]    = det_ff[1];
         nxt_code[`RLSC_CODE_UP]    = det_ff[0];
      end
      nxt_hdlc[`RLSC_PS_LSB +: `RLSC_PS_W] = pkt_ff;
      nxt_hdlc[`RLSC_HDLC_HWM] = fifo_level_in > {1'b0, fifoctl_ff[`RLSC_WM_W-1:0]};
      nxt_hdlc[`RLSC_HDLC_NE]  = fifo_level_in != 7'h00;
      nxt_bytes[`RLSC_MS_BIT] = fifo_level_in == 7'h00 || !msg_end_in;
      nxt_bytes[`RLSC_CNT_W-1:0] = packet_byte_count_in;
   end

   // live status refreshed every enabled cycle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         alarm_ff <= `RLSC_REG_RESET;
         code_ff  <= `RLSC_REG_RESET;
         hdlc_ff  <= `RLSC_REG_RESET;
         bytes_ff <= `RLSC_REG_RESET;
      end else if (ce_in) begin
         alarm_ff <= nxt_alarm;
         code_ff  <= nxt_code;
         hdlc_ff  <= nxt_hdlc;
         bytes_ff <= nxt_bytes;
      end
   end

   los_after_zeros_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && line_bit_valid_in && !line_bit_in && zero_run_ff == 8'hbf) ##1 ce_in
      |=> alarm_ff[`RLSC_ALM_LOS])
      else $error("signal lost bit missing after zero run");
   lof_live_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ce_in |=> alarm_ff[`RLSC_ALM_LOF] == !$past(rx_in_sync_in))
      else $error("frame lost bit does not follow sync");
   rai_live_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && !rx_remote_alarm_in) |=> !alarm_ff[`RLSC_ALM_RAI])
      else $error("remote alarm bit held after condition ended");
   restart_clears_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && restart[1]) |=> (!det_ff[1] && integ_ff[1] == '0))
      else $error("down code write did not restart integration");
   pkt_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && !fifo_read_in) |=> $stable(pkt_ff))
      else $error("packet state changed without fifo read");
   pkt_legal_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      hdlc_ff[`RLSC_PS_LSB +: `RLSC_PS_W] <= RLSC_PKT_OVERRUN)
      else $error("undefined packet state shown");
   fifo_nonempty_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ce_in |=> hdlc_ff[`RLSC_HDLC_NE] == ($past(fifo_level_in) != 7'h00))
      else $error("not empty bit wrong");
   msg_empty_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && fifo_level_in == 7'h00) |=> bytes_ff[`RLSC_MS_BIT])
      else $error("message bit not one on empty fifo");
   clock_stall_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && rx_clk_level_in != clk_prev_ff) ##1 ce_in |=> !code_ff[`RLSC_CODE_RX_CLOCK_LOST])
      else $error("clock lost shown after transition");
   dma_two_mf_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && e1_mode && !mf_hist_ff[0]) |=> !code_ff[`RLSC_CODE_DMA])
      else $error("distant multiframe alarm without two set bits");

endmodule : rlsc_top

/* File: dv/rlsc_line_model.sv */
/*
 Line-side model: repeats a pattern MSB first, one decoded bit every fourth
 cycle, and makes a receive clock level that the bench may stop.
 Assumes the bench changes pattern and length at clock edges.
*/
`timescale 1ns/1ps
module rlsc_line_model (
   input  wire logic       core_clk_in,            // bench clock
   input  wire logic [7:0] pat_in,                 // pattern, first bit in 7
   input  wire logic [2:0] len_in,                 // pattern length minus one
   input  wire logic       clk_run_in,             // receive clock runs
   output logic            line_bit_out = 1'b0,    // decoded bit
   output logic            line_bit_valid_out = 1'b0, // bit strobe
   output logic            rx_clk_out = 1'b0       // receive clock level
);
   logic [1:0] div_ff = 2'h0;
   logic [2:0] pos_ff = 3'h0;
   // a stopped receive clock holds its level, as a dead line would
   always @(posedge core_clk_in) begin
      div_ff <= div_ff + 2'h1;
      line_bit_valid_out <= (div_ff == 2'h3);
      if (div_ff == 2'h3) begin
         line_bit_out <= pat_in[3'h7 - pos_ff];
         pos_ff <= (pos_ff >= len_in) ? 3'h0 : pos_ff + 3'h1;
      end
      if (clk_run_in) rx_clk_out <= ~rx_clk_out;
   end
endmodule : rlsc_line_model

/* File: dv/testbench.sv */
/*
 Self-checking bench: AXI4-Lite tasks, a line model and status inputs.
 Assumes the design answers every request it takes.
*/
`timescale 1ns/1ps
`include "rlsc_regs.svh"
module testbench;
   import rlsc_pkg::*;
   localparam logic [1:0] OK = `RLSC_RESP_OKAY;
   localparam logic [1:0] ERR = `RLSC_RESP_SLVERR;
   logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic sync = 1, rai = 0, spare = 0, v5 = 0, ts6 = 0, tsv = 0, frd = 0, mend = 1, run = 1;
   logic [9:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic [6:0] lvl = '0, cnt = '0;
   logic [2:0] ps = '0, mlen = 3'h2;
   logic [7:0] pat = 8'hc0;
   wire awready, wready, bvalid, arready, rvalid, lbit, lval, rxc;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int n_errors = 0, checks_done = 0;
   rlsc_byte_t rst_idx[10] = '{8'hac, 8'had, 8'hae, 8'haf, 8'hb0, 8'hb2, 8'hb4, 8'hb8,
                               8'hb9, 8'hba};
   always #5 clk = ~clk;
   rlsc_top #(.INTEG_BITS(8)) DUT (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .line_bit_in(lbit),
      .line_bit_valid_in(lval), .rx_clk_level_in(rxc), .rx_in_sync_in(sync),
      .rx_remote_alarm_in(rai), .spare_code_in(spare), .v5_link_in(v5),
      .mf_ts16_bit6_in(ts6), .mf_ts16_valid_in(tsv), .fifo_level_in(lvl),
      .fifo_read_in(frd), .packet_state_in(ps), .packet_byte_count_in(cnt),
      .msg_end_in(mend));
   rlsc_line_model line_model (.core_clk_in(clk), .pat_in(pat), .len_in(mlen),
      .clk_run_in(run), .line_bit_out(lbit), .line_bit_valid_out(lval), .rx_clk_out(rxc));
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic chk_byte(input rlsc_byte_t g, input rlsc_byte_t e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_byte
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_resp
   task automatic wr(input rlsc_byte_t idx, input rlsc_byte_t d, input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 0;
      w_done = 0;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1;
            awvalid <= 0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1;
            wvalid <= 0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      chk_resp(bresp, er);
      bready <= 0;
   endtask : wr
   task automatic rd(input rlsc_byte_t idx, input rlsc_byte_t e, input logic [1:0] er = OK);
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk_byte(rdata[7:0], e);
      chk_resp(rresp, er);
      rready <= 0;
   endtask : rd
   task automatic pulse_read;
      frd <= 1;
      @(posedge clk);
      frd <= 0;
   endtask : pulse_read
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      foreach (rst_idx[i]) rd(rst_idx[i], 8'h00);
      rd(8'hb1, 8'h00, ERR);
      wr(8'hbb, 8'h5a, ERR);
      $display("test reset_and_map done");
      wr(`RLSC_IDX_LEN, 8'h33, OK);
      wr(`RLSC_IDX_UP_LO, 8'ha5, OK);
      wr(`RLSC_IDX_UP_HI, 8'hff, OK);
      wr(`RLSC_IDX_DN_LO, 8'h5c, OK);
      wr(`RLSC_IDX_DN_HI, 8'h3c, OK);
      rd(`RLSC_IDX_DN_HI, 8'h3c);
      pat <= 8'ha0;
      mlen <= 3'h3;
      repeat (200) @(posedge clk);
      rd(`RLSC_IDX_CODE, 8'h03);
      wr(`RLSC_IDX_DN_LO, 8'h5c, OK);
      rd(`RLSC_IDX_CODE, 8'h01);
      repeat (200) @(posedge clk);
      rd(`RLSC_IDX_CODE, 8'h03);
      // 110100 for up, its mirror 001011 for down: only msb-first order detects up
      wr(`RLSC_IDX_LEN, 8'h55, OK);
      wr(`RLSC_IDX_UP_LO, 8'hd0, OK);
      wr(`RLSC_IDX_DN_LO, 8'h2c, OK);
      pat <= 8'hd0;
      mlen <= 3'h5;
      repeat (200) @(posedge clk);
      rd(`RLSC_IDX_CODE, 8'h01);
      $display("test loop_codes done");
      pat <= 8'hff;
      mlen <= 3'h0;
      sync <= 0;
      repeat (900) @(posedge clk);
      rd(`RLSC_IDX_CODE, 8'h00);
      rd(`RLSC_IDX_ALARM, 8'h05);
      pat <= 8'h00;
      sync <= 1;
      repeat (900) @(posedge clk);
      rd(`RLSC_IDX_ALARM, 8'h02);
      pat <= 8'hc0;
      mlen <= 3'h2;
      rai <= 1;
      repeat (16) @(posedge clk);
      rd(`RLSC_IDX_ALARM, 8'h08);
      rai <= 0;
      rd(`RLSC_IDX_ALARM, 8'h00);
      run <= 0;
      spare <= 1;
      repeat (600) @(posedge clk);
      rd(`RLSC_IDX_CODE, 8'h0c);
      run <= 1;
      spare <= 0;
      repeat (4) @(posedge clk);
      rd(`RLSC_IDX_CODE, 8'h00);
      $display("test alarms done");
      wr(`RLSC_IDX_MODE, 8'h01, OK);
      v5 <= 1;
      ts6 <= 1;
      tsv <= 1;
      @(posedge clk);
      tsv <= 0;
      rd(`RLSC_IDX_CODE, 8'h02);
      tsv <= 1;
      @(posedge clk);
      tsv <= 0;
      rd(`RLSC_IDX_CODE, 8'h03);
      $display("test e1_status done");
      wr(`RLSC_IDX_FIFOCTL, 8'h20, OK);
      lvl <= 7'h20;
      for (int k = 0; k < 5; k++) begin
         ps <= k[2:0];
         pulse_read();
         rd(`RLSC_IDX_HDLC, {1'b0, k[2:0], 4'h1});
      end
      ps <= 3'h5;
      pulse_read();
      ps <= 3'h2;
      lvl <= 7'h21;
      rd(`RLSC_IDX_HDLC, 8'h43);
      cnt <= 7'h15;
      rd(`RLSC_IDX_BYTES, 8'h15);
      mend <= 0;
      rd(`RLSC_IDX_BYTES, 8'h95);
      mend <= 1;
      lvl <= 7'h00;
      rd(`RLSC_IDX_BYTES, 8'h95);
      rd(`RLSC_IDX_HDLC, 8'h40);
      $display("test hdlc_status done");
      give_verdict();
   end
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
endmodule : testbench
